// >>> logic/dsm_colour_div.sv
`timescale 1ns/1ps
module dsm_colour_div
    import dsm_pkg::*;
(
    input  wire logic sys_clk_i,            // System clock
    input  wire logic srst_i,               // Sync reset, high
    input  wire logic ce_i,                 // Clock enable
    input  wire logic crystal_in_i,         // Crystal or square wave
    output logic      colour_clock_out_o,   // Crystal divided by four
    output logic      crystal_drive_out_o   // Inverted crystal feedback
);

    dsm_cc_state_t st;
    dsm_cc_state_t n;
    logic          rise_w;

    assign rise_w = crystal_in_i & ~st.xt_d;

    always_comb begin
        n      = st;
        n.xt_d = crystal_in_i;
        n.drive = ~crystal_in_i;
        if (rise_w) begin
            // Two-bit divider, output toggles each second crystal rise  [R11] [R21]
            n.div = st.div + 2'h1;
            if (st.div[0]) begin
                n.colour = ~st.colour;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            st <= CC_STATE_RST;
        end else if (ce_i) begin
            st <= n;
        end
    end

    assign colour_clock_out_o  = st.colour;
    assign crystal_drive_out_o = st.drive;

    AST_COLOUR_DIV: assert property (@(posedge sys_clk_i) disable iff (srst_i || !ce_i) // [R11]
        (rise_w && st.div == COLOUR_DIV_LAST) |=> $changed(colour_clock_out_o))
        else $error("colour clock did not toggle on fourth crystal edge");

endmodule // dsm_colour_div

// >>> logic/dsm_pkg.sv
package dsm_pkg;

    // ------------------------------------------------------------------
    // Clock and widths
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_MHZ  = 125;
    localparam int CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;
    localparam int CNT_W         = 8;
    localparam int CPU_ADDR_W    = 16;
    localparam int DRAM_ADDR_W   = 8;
    localparam int RST_CNT_W     = 4;
    localparam int RESET_PHASES_DEF = 4;

    // ------------------------------------------------------------------
    // Timing figures, ns from the phase clock falling edge; RCD, hold and write pass times from other edges
    // ------------------------------------------------------------------
    localparam int ADDR_VALID_NS   = 145;
    localparam int RAS_FALL_MIN_NS = 210;
    localparam int RAS_FALL_MAX_NS = 305;
    localparam int RCD_NS          = 80;
    localparam int CAS_RD_MIN_NS   = 300;
    localparam int CAS_RD_MAX_NS   = 370;
    localparam int CAS_WR_NS       = 425;
    localparam int CAS_RISE_MIN_NS = 10;
    localparam int CAS_RISE_MAX_NS = 100;
    localparam int ROW_HOLD_NS     = 30;
    localparam int COL_HOLD_NS     = 80;
    localparam int WRT_PASS_NS     = 50;
    localparam int LE_FALL_MIN_NS  = 240;
    localparam int LE_FALL_MAX_NS  = 360;
    localparam int LE_RISE_MIN_NS  = 440;
    localparam int LE_RISE_MAX_NS  = 600;
    localparam int OE_FALL_MIN_NS  = 240;
    localparam int OE_FALL_MAX_NS  = 450;
    localparam int OE_RISE_MIN_NS  = 570;
    localparam int OE_RISE_MAX_NS  = 660;

    // ------------------------------------------------------------------
    // Cycle counts, least times rounded up
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] CAS_RISE_CYC =
        CNT_W'((CAS_RISE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CAPTURE_CYC =
        CNT_W'((ADDR_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CAS_RD_CYC =
        CNT_W'((CAS_RD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RCD_CYC =
        CNT_W'((RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RAS_CYC = CAS_RD_CYC - RCD_CYC;
    localparam logic [CNT_W-1:0] ROW_HOLD_CYC =
        CNT_W'((ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] COL_SEL_CYC = RAS_CYC + ROW_HOLD_CYC;
    localparam logic [CNT_W-1:0] CAS_WR_CYC =
        CNT_W'((CAS_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] LE_FALL_CYC =
        CNT_W'((LE_FALL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] LE_RISE_CYC =
        CNT_W'((LE_RISE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] OE_FALL_CYC =
        CNT_W'((OE_FALL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] OE_RISE_CYC =
        CNT_W'((OE_RISE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_SAT = 8'hFF;

    // ------------------------------------------------------------------
    // Address map and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] LOW_BANK_TOP = 2'h0;
    localparam int         BANK_MSB     = 15;
    localparam int         BANK_LSB     = 14;
    localparam logic [1:0] COLOUR_DIV_LAST = 2'h3;

    typedef enum logic [1:0] {
        DSM_PORT_IDLE  = 2'b00,
        DSM_PORT_READ  = 2'b01,
        DSM_PORT_WRITE = 2'b10
    } dsm_port_op_t;

    typedef struct packed {
        logic                   ph_d;
        logic                   rst_d;
        logic [CNT_W-1:0]       cnt;
        logic                   ras_n;
        logic                   cas_n;
        logic                   col_sel;
        logic                   wrt_n;
        logic                   inhibit;
        logic [CPU_ADDR_W-1:0]  cyc_addr;
        logic                   rst_busy;
        logic [RST_CNT_W-1:0]   rst_left;
        dsm_port_op_t           port_op;
        logic [CNT_W-1:0]       port_cnt;
        logic                   oe_n;
        logic                   le_n;
        logic [DRAM_ADDR_W-1:0] dram_addr;
    } dsm_state_t;

    localparam dsm_state_t STATE_RST = '{
        ph_d: 1'b0, rst_d: 1'b1, cnt: CNT_SAT, ras_n: 1'b1, cas_n: 1'b1,
        col_sel: 1'b0, wrt_n: 1'b1, inhibit: 1'b1, cyc_addr: 16'h0000,
        rst_busy: 1'b0, rst_left: 4'h0, port_op: DSM_PORT_IDLE,
        port_cnt: 8'h00, oe_n: 1'b1, le_n: 1'b1, dram_addr: 8'h00};

    typedef struct packed {
        logic       xt_d;
        logic [1:0] div;
        logic       colour;
        logic       drive;
    } dsm_cc_state_t;

    localparam dsm_cc_state_t CC_STATE_RST = '{
        xt_d: 1'b0, div: 2'h0, colour: 1'b0, drive: 1'b1};

endpackage

// >>> logic/dsm_strobe_mux.sv
// Contract
// [R1] Send 16-bit address as an 8-bit row half then column half per cycle.
// [R2] Row strobe falls only while the address port holds the row.
// [R3] Column strobe falls only while the address port holds the column.
// [R4] Low-bank column strobe follows column strobe below 4000, high above.
// [R5] Write strobe is latched read/write, stable until both strobes rise.
// [R6] While the latch loads, read/write reaches the write strobe within 50 ns.
// [R7] External select low forces the column strobe high immediately.
// [R8] Column inhibit sampled at cycle start keeps column strobe high all cycle.
// [R9] Reset falling edge sets write latch to read and inhibits column strobe.
// [R10] After reset actions, normal cycles resume though reset stays low.
// [R11] Output a 3.579545 MHz clock from the 14.31818 MHz crystal.
// [R12] Port control: both low reset, enable low read, latch low write.
// [R13] Row strobe falls 210 to 305 ns after the phase clock falls.
// [R14] Column strobe falls 300-370 ns after phase fall on reads, 425 on writes.
// [R15] Previous column strobe rises 10-100 ns after phase fall, before row.
// [R16] Column strobe falls 80 ns after row strobe on reads.
// [R17] Row address held 30 ns after row strobe falls.
// [R18] Column address held 80 ns after column strobe falls.
// [R19] Port write: latch enable low from 240-360 ns to 440-600 ns.
// [R20] Port read: output enable low from 240-450 ns to 570-660 ns.
// [R21] Colour clock is crystal over four; strobes timed from phase falls.
`timescale 1ns/1ps
module dsm_strobe_mux
    import dsm_pkg::*;
#(
    parameter int RESET_PHASES = RESET_PHASES_DEF   // Phase cycles of reset action
)(
    input  wire logic                   sys_clk_i,               // 125 MHz clock
    input  wire logic                   srst_i,                  // Sync reset, high
    input  wire logic                   ce_i,                    // Clock enable
    input  wire logic                   cpu_phase_clock_i,       // Processor phase clock
    input  wire logic [CPU_ADDR_W-1:0]  cpu_addr_i,              // Processor address
    input  wire logic                   cpu_rw_n_i,              // High read, low write
    input  wire logic                   cpu_reset_n_i,           // Processor reset, low
    input  wire logic                   external_select_n_i,     // External select, low
    input  wire logic                   col_inhibit_n_i,         // Column inhibit, low
    input  wire logic                   port_sel_i,              // Port register access
    input  wire logic                   crystal_in_i,            // Crystal input
    output logic      [DRAM_ADDR_W-1:0] dram_addr_o,             // Muxed DRAM address
    output logic                        row_strobe_n_o,          // Row strobe, low
    output logic                        col_strobe_n_o,          // Column strobe, low
    output logic                        low_bank_col_strobe_n_o, // Low 16K column strobe
    output logic                        write_strobe_n_o,        // DRAM write, low
    output logic                        port_output_enable_n_o,  // Port output enable
    output logic                        port_latch_enable_n_o,   // Port latch enable
    output logic                        colour_clock_out_o,      // Colour clock
    output logic                        crystal_drive_out_o      // Crystal feedback
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    generate
        if (RESET_PHASES < 1 || RESET_PHASES > 15) begin : g_bad_reset_phases
            $error("RESET_PHASES must lie in 1..15");
        end
    endgenerate

    localparam logic [RST_CNT_W-1:0] RST_LOAD = RST_CNT_W'(RESET_PHASES);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    dsm_state_t st;
    dsm_state_t n;
    logic       fall_w;
    logic       rst_edge_w;
    logic       cap_w;
    logic       high_bank_w;

    assign fall_w     = st.ph_d & ~cpu_phase_clock_i;
    assign rst_edge_w = st.rst_d & ~cpu_reset_n_i;

    always_comb begin
        n       = st;
        n.ph_d  = cpu_phase_clock_i;
        n.rst_d = cpu_reset_n_i;

        // Cycle timer restarts on every phase fall  [R21]
        if (fall_w) begin
            n.cnt = '0;
        end else if (st.cnt != CNT_SAT) begin
            n.cnt = st.cnt + 8'h01;
        end

        // Reset action spans several phase cycles, then lets go  [R9] [R10]
        if (rst_edge_w) begin
            n.rst_busy = 1'b1;
            n.rst_left = RST_LOAD;
        end else if (fall_w && st.rst_busy) begin
            n.rst_left = st.rst_left - 4'h1;
            if (st.rst_left == 4'h1) begin
                n.rst_busy = 1'b0;
            end
        end

        // Inhibit latched at cycle start, forced during reset action  [R8] [R9]
        if (rst_edge_w) begin
            n.inhibit = 1'b1;
        end else if (fall_w) begin
            n.inhibit = ~col_inhibit_n_i | n.rst_busy;
        end

        // Both strobes end together shortly after the phase fall  [R15]
        if (n.cnt == CAS_RISE_CYC) begin
            n.ras_n   = 1'b1;
            n.cas_n   = 1'b1;
            n.col_sel = 1'b0;
        end

        if (n.cnt == CAPTURE_CYC) begin
            n.cyc_addr = cpu_addr_i;
        end

        // Row strobe only after the row half has settled on the port  [R2] [R13]
        if (n.cnt == RAS_CYC) begin
            n.ras_n = 1'b0;
        end

        // Column half appears once row hold has elapsed  [R1] [R17]
        if (n.cnt == COL_SEL_CYC) begin
            n.col_sel = 1'b1;
        end

        // Column strobe: read uses row+80 ns, write waits for data  [R3] [R14] [R16]
        if (!st.inhibit && st.col_sel) begin
            if (st.wrt_n && n.cnt == CAS_RD_CYC) begin
                n.cas_n = 1'b0;
            end
            if (!st.wrt_n && n.cnt == CAS_WR_CYC) begin
                n.cas_n = 1'b0;
            end
        end

        // Column kept until the strobe rises in the next cycle  [R1] [R18]
        if (n.col_sel) begin
            n.dram_addr = st.cyc_addr[CPU_ADDR_W-1:DRAM_ADDR_W];
        end else begin
            n.dram_addr = cpu_addr_i[DRAM_ADDR_W-1:0];
        end

        // Transparent latch, closed while either internal strobe is low  [R5] [R6] [R9]
        if (rst_edge_w || n.rst_busy) begin
            n.wrt_n = 1'b1;
        end else if (st.ras_n && st.cas_n) begin
            n.wrt_n = cpu_rw_n_i;
        end

        // Port register access sequencing  [R19] [R20]
        if (n.cnt == CAPTURE_CYC && port_sel_i) begin
            n.port_op  = cpu_rw_n_i ? DSM_PORT_READ : DSM_PORT_WRITE;
            n.port_cnt = CAPTURE_CYC;
        end else begin
            unique case (st.port_op)
                DSM_PORT_IDLE: begin
                    n.port_cnt = '0;
                end
                DSM_PORT_READ, DSM_PORT_WRITE: begin
                    n.port_cnt = st.port_cnt + 8'h01;
                    if (n.port_cnt == OE_RISE_CYC) begin
                        n.port_op = DSM_PORT_IDLE;
                    end
                end
                default: begin
                    n.port_op  = DSM_PORT_IDLE;
                    n.port_cnt = '0;
                end
            endcase
        end

        // Control pair encoding: reset, read, write, hold  [R12] [R19] [R20]
        n.le_n = 1'b1;
        n.oe_n = 1'b1;
        if (n.rst_busy) begin
            n.le_n = 1'b0;
            n.oe_n = 1'b0;
        end else if (n.port_op == DSM_PORT_WRITE) begin
            n.le_n = ~(n.port_cnt >= LE_FALL_CYC && n.port_cnt < LE_RISE_CYC);
        end else if (n.port_op == DSM_PORT_READ) begin
            n.oe_n = ~(n.port_cnt >= OE_FALL_CYC && n.port_cnt < OE_RISE_CYC);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            st <= STATE_RST;
        end else if (ce_i) begin
            st <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign cap_w       = (n.cnt == CAPTURE_CYC) && (st.cnt != CAPTURE_CYC);
    assign high_bank_w = (st.cyc_addr[BANK_MSB:BANK_LSB] != LOW_BANK_TOP);

    assign dram_addr_o             = st.dram_addr;
    assign row_strobe_n_o          = st.ras_n;
    // Combinational on purpose: select must win without a clock edge  [R7]
    assign col_strobe_n_o          = st.cas_n | ~external_select_n_i;
    assign low_bank_col_strobe_n_o = col_strobe_n_o | high_bank_w;       // [R4]
    assign write_strobe_n_o        = st.wrt_n;
    assign port_output_enable_n_o  = st.oe_n;
    assign port_latch_enable_n_o   = st.le_n;

    dsm_colour_div u_colour_div (
        .sys_clk_i           (sys_clk_i),
        .srst_i              (srst_i),
        .ce_i                (ce_i),
        .crystal_in_i        (crystal_in_i),
        .colour_clock_out_o  (colour_clock_out_o),
        .crystal_drive_out_o (crystal_drive_out_o)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    localparam int C_RAS_D   = int'(RAS_CYC) + 1;
    localparam int C_RCD_D   = int'(CAS_RD_CYC) - int'(RAS_CYC);
    localparam int C_WR_D    = int'(CAS_WR_CYC) - int'(RAS_CYC);
    localparam int C_RISE_D  = int'(CAS_RISE_CYC) + 1;
    localparam int C_INH_D   = int'(CAS_WR_CYC) + 1;
    localparam int C_LEF_D   = int'(LE_FALL_CYC) - int'(CAPTURE_CYC) + 1;
    localparam int C_LER_D   = int'(LE_RISE_CYC) - int'(LE_FALL_CYC);
    localparam int C_OEF_D   = int'(OE_FALL_CYC) - int'(CAPTURE_CYC) + 1;
    localparam int C_OER_D   = int'(OE_RISE_CYC) - int'(OE_FALL_CYC);

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i || !ce_i);

    sequence s_le_pulse;
        ##C_LEF_D $fell(port_latch_enable_n_o) ##C_LER_D $rose(port_latch_enable_n_o);
    endsequence

    sequence s_oe_pulse;
        ##C_OEF_D $fell(port_output_enable_n_o) ##C_OER_D $rose(port_output_enable_n_o);
    endsequence

    sequence s_port_start(logic wr);
        cap_w && port_sel_i && (cpu_rw_n_i == !wr) && !st.rst_busy && cpu_reset_n_i;
    endsequence

    AST_RAS_AFTER_PHASE: assert property ( // [R13]
        (fall_w && st.cnt > RAS_CYC && cpu_phase_clock_i == 1'b0)
        |-> ##C_RAS_D $fell(row_strobe_n_o))
        else $error("row strobe not at its slot after phase fall");

    AST_RCD_READ: assert property ( // [R16]
        ($fell(row_strobe_n_o) && st.wrt_n && !st.inhibit && external_select_n_i)
        |-> ##C_RCD_D $fell(st.cas_n))
        else $error("read column strobe not 80 ns after row strobe");

    AST_CAS_WRITE: assert property ( // [R14]
        ($fell(row_strobe_n_o) && !st.wrt_n && !st.inhibit)
        |-> ##C_WR_D $fell(st.cas_n))
        else $error("write column strobe not at 425 ns slot");

    AST_CAS_RISE: assert property ( // [R15]
        (fall_w && !st.cas_n) |-> ##C_RISE_D (st.cas_n && st.ras_n))
        else $error("previous column strobe did not end after phase fall");

    AST_ROW_HOLD: assert property ( // [R17]
        $fell(row_strobe_n_o) |-> (!st.col_sel) [*4])
        else $error("row address not held after row strobe");

    AST_COL_HOLD: assert property ( // [R18]
        $fell(st.cas_n) |-> (st.col_sel && !st.cas_n) [*8])
        else $error("column address not held after column strobe");

    AST_ADDR_MUX: assert property ( // [R1]
        ($rose(st.col_sel)) |=> (dram_addr_o == st.cyc_addr[CPU_ADDR_W-1:DRAM_ADDR_W]))
        else $error("column half not presented on address port");

    AST_LOW_BANK: assert property ( // [R4]
        ($fell(st.cas_n) && external_select_n_i)
        |-> (low_bank_col_strobe_n_o == (st.cyc_addr[BANK_MSB:BANK_LSB] != LOW_BANK_TOP)))
        else $error("low-bank column strobe wrong for the address");

    AST_EXT_SELECT: assert property ( // [R7]
        (!external_select_n_i) |-> (col_strobe_n_o && low_bank_col_strobe_n_o))
        else $error("column strobe low while external select low");

    AST_INHIBIT: assert property ( // [R8]
        (fall_w && !col_inhibit_n_i) |-> ##C_INH_D st.cas_n)
        else $error("column strobe fell in an inhibited cycle");

    AST_WRT_PASS: assert property ( // [R6]
        (st.ras_n && st.cas_n && !n.rst_busy && !rst_edge_w)
        |=> (write_strobe_n_o == $past(cpu_rw_n_i)))
        else $error("read/write not passed through the open latch");

    AST_WRT_HOLD: assert property ( // [R5]
        ((!st.ras_n || !st.cas_n) && !st.rst_busy && cpu_reset_n_i)
        |=> $stable(write_strobe_n_o))
        else $error("write strobe moved while a strobe was low");

    AST_RESET_ACTION: assert property ( // [R9]
        rst_edge_w |=> (write_strobe_n_o && st.inhibit
                        && !port_output_enable_n_o && !port_latch_enable_n_o))
        else $error("reset edge did not force read and inhibit");

    AST_RESET_RELEASE: assert property ( // [R10]
        (fall_w && st.rst_busy && st.rst_left == 4'h1 && !rst_edge_w)
        |=> (!st.rst_busy && port_output_enable_n_o && port_latch_enable_n_o))
        else $error("reset action did not end after its phase count");

    AST_PORT_WRITE: assert property ( // [R19]
        s_port_start(1'b1) |-> s_le_pulse)
        else $error("port latch enable pulse mistimed");

    AST_PORT_READ: assert property ( // [R20]
        s_port_start(1'b0) |-> s_oe_pulse)
        else $error("port output enable pulse mistimed");

endmodule // dsm_strobe_mux

// >>> tb/dsm_dram_model.sv
`timescale 1ns/1ps
module dsm_dram_model
    import dsm_pkg::*;
(
    input  wire logic                   row_n_i, // Row strobe
    input  wire logic                   col_n_i, // Column strobe
    input  wire logic                   wr_n_i,  // Write strobe
    input  wire logic [DRAM_ADDR_W-1:0] addr_i,  // Muxed address
    output logic      [DRAM_ADDR_W-1:0] row_o,   // Last row taken
    output logic      [DRAM_ADDR_W-1:0] col_o,   // Last column taken
    output logic                        wr_o,    // Last access wrote
    output logic                        ok_o     // Hold times met
);
    initial ok_o = 1'b1;
    always @(negedge row_n_i) begin
        row_o = addr_i;
        #29;
        if (addr_i !== row_o) ok_o = 1'b0;
    end
    always @(negedge col_n_i) begin
        col_o = addr_i;
        wr_o = ~wr_n_i;
        #79;
        if (addr_i !== col_o) ok_o = 1'b0;
    end
endmodule // dsm_dram_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import dsm_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        srst_i    = 1'b1;
    logic        ph        = 1'b1;
    logic        rw_n      = 1'b1;
    logic        rst_n     = 1'b1;
    logic        ext_n     = 1'b1;
    logic        inh_n     = 1'b1;
    logic        port      = 1'b0;
    logic        xtal      = 1'b0;
    logic [15:0] addr      = 16'h0000;
    logic [7:0]  ra, m_row, m_col;
    logic        row_n, col_n, lb_n, wr_n, oe_n, le_n, clr, xdrv, m_wr, m_ok;
    int          num_errors, n_compared, n_cyc, n_col, c0;
    real         t_ph;
    real         tm[9];

    always #4 sys_clk_i = ~sys_clk_i;
    always begin
        repeat (4) @(negedge sys_clk_i);
        xtal = ~xtal;
    end
    always @(posedge clr) n_col++;
    always @(negedge row_n) tm[0] = $realtime - t_ph;
    always @(negedge col_n) tm[1] = $realtime - t_ph;
    always @(posedge col_n) tm[2] = $realtime - t_ph;
    always @(negedge lb_n) tm[3] = $realtime - t_ph;
    always @(negedge le_n) tm[4] = $realtime - t_ph;
    always @(posedge le_n) tm[5] = $realtime - t_ph;
    always @(negedge oe_n) tm[6] = $realtime - t_ph;
    always @(posedge oe_n) tm[7] = $realtime - t_ph;
    always @(negedge wr_n) tm[8] = $realtime - t_ph;

    dsm_strobe_mux #(.RESET_PHASES(1)) dut (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(1'b1),
        .cpu_phase_clock_i(ph), .cpu_addr_i(addr), .cpu_rw_n_i(rw_n),
        .cpu_reset_n_i(rst_n), .external_select_n_i(ext_n), .col_inhibit_n_i(inh_n),
        .port_sel_i(port), .crystal_in_i(xtal), .dram_addr_o(ra), .row_strobe_n_o(row_n),
        .col_strobe_n_o(col_n), .low_bank_col_strobe_n_o(lb_n), .write_strobe_n_o(wr_n),
        .port_output_enable_n_o(oe_n), .port_latch_enable_n_o(le_n),
        .colour_clock_out_o(clr), .crystal_drive_out_o(xdrv));
    dsm_dram_model ram (.row_n_i(row_n), .col_n_i(col_n), .wr_n_i(wr_n), .addr_i(ra),
        .row_o(m_row), .col_o(m_col), .wr_o(m_wr), .ok_o(m_ok));

    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic cmp_ns(input real t, input real lo, input real hi, input string what);
        n_compared++;
        if (t < lo || t > hi) begin
            num_errors++;
            $display("mismatch at %0t: %s at %0.1f", $time, what, t);
        end
    endtask
    // One phase cycle: low 35 clocks, high 35 clocks
    task automatic cyc(input logic [15:0] a, input logic rw, input logic p, input logic ci);
        @(negedge sys_clk_i);
        foreach (tm[i]) tm[i] = -1.0;
        // Inputs are synchronous: the phase fall counts from the edge that samples it
        t_ph = $realtime + CLK_PERIOD_NS / 2.0;
        ph = 1'b0;
        addr = a;
        rw_n = rw;
        port = p;
        inh_n = ci;
        repeat (35) @(negedge sys_clk_i);
        ph = 1'b1;
        repeat (35) @(negedge sys_clk_i);
    endtask

    always @(posedge sys_clk_i) begin
        n_cyc++;
        if (n_cyc == 5000) begin
            num_errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (16) @(negedge sys_clk_i);
        srst_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        cyc(16'h3F5A, 1'b1, 1'b0, 1'b1);
        cmp_bit(m_row === 8'h5A && m_col === 8'h3F, 1'b1, "row/col");
        cmp_bit(m_ok & ~m_wr, 1'b1, "hold or write");
        cmp_ns(tm[0], 210, 305, "row fall");
        cmp_ns(tm[1], 300, 370, "col fall read");
        cmp_ns(tm[1] - tm[0], 80, 80, "row to col");
        cmp_ns(tm[3], tm[1], tm[1], "low bank");
        $display("done read");
        cyc(16'h4001, 1'b0, 1'b0, 1'b1);
        cmp_ns(tm[2], 10, 100, "col rise");
        cmp_ns(tm[0] - tm[2], 0, 400, "row after col rise");
        cmp_ns(tm[8], 0, 50, "write pass");
        cmp_ns(tm[1], 425, 433, "col fall write");
        cmp_ns(tm[3], -1, -1, "low bank high");
        cmp_bit(m_row === 8'h01 && m_col === 8'h40 && m_wr, 1'b1, "write");
        rw_n = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        cmp_bit(wr_n, 1'b0, "write held");
        rst_n = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        cmp_bit(wr_n, 1'b1, "reset action");
        cmp_bit(oe_n | le_n, 1'b0, "port reset");
        cyc(16'h0100, 1'b1, 1'b0, 1'b1);
        cyc(16'h0100, 1'b1, 1'b0, 1'b1);
        cmp_ns(tm[1], 300, 370, "resumed");
        cmp_bit(oe_n & le_n, 1'b1, "port hold");
        rst_n = 1'b1;
        $display("done reset");
        cyc(16'h0010, 1'b1, 1'b0, 1'b0);
        cmp_ns(tm[1], -1, -1, "inhibit");
        cmp_ns(tm[0], 210, 305, "row under inhibit");
        fork
            cyc(16'h2000, 1'b1, 1'b0, 1'b1);
            begin
                repeat (42) @(negedge sys_clk_i);
                ext_n = 1'b0;
                #1 cmp_bit(col_n & lb_n, 1'b1, "ext select");
                repeat (2) @(negedge sys_clk_i);
                ext_n = 1'b1;
                #1 cmp_bit(col_n, 1'b0, "ext release");
            end
        join
        cyc(16'h0300, 1'b0, 1'b1, 1'b1);
        cmp_ns(tm[4], 240, 360, "le fall");
        cmp_ns(tm[5], 440, 600, "le rise");
        cmp_ns(tm[6], -1, -1, "no oe");
        cyc(16'h0300, 1'b1, 1'b1, 1'b1);
        repeat (4) @(negedge sys_clk_i);
        cmp_ns(tm[6], 240, 450, "oe fall");
        cmp_ns(tm[7], 570, 660, "oe rise");
        cmp_ns(tm[4], -1, -1, "no le");
        @(posedge xtal);
        c0 = n_col;
        repeat (2) @(posedge sys_clk_i);
        #1 cmp_bit(xdrv, 1'b0, "crystal drive");
        repeat (32) @(posedge xtal);
        cmp_ns(real'(n_col - c0), 8, 8, "colour rate");
        $display("done port and colour");
        give_verdict();
    end
endmodule // tb_top
